// [design/adcs_pkg.sv]
package adcs_pkg;

  // ****************************************
  // Clock and timing figures
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam logic [12:0] WIDE_LEN = 13'h002C;
  localparam logic [12:0] NARROW_LEN = 13'h0015;
  localparam logic [12:0] ACQ0_LEN = 13'h0006;
  localparam logic [12:0] ACQ1_LEN = 13'h000A;
  localparam logic [12:0] ACQ2_LEN = 13'h0012;
  localparam logic [12:0] ACQ3_LEN = 13'h0022;
  localparam int CAL_LEN_DEF = 4944;
  localparam logic [12:0] ZERO_LEN = 13'h004C;
  localparam logic [12:0] SYNC_MIN_LEN = 13'h0002;
  localparam logic [12:0] SYNC_MAX_LEN = 13'h0003;
  localparam logic [3:0] RDY_HIGH_SCLK = 4'h9;
  localparam logic [3:0] SEL_VALID_SCLK = 4'h8;
  localparam int PU_MAX_US = 700;
  localparam int HPU_TYP_US = 250;
  localparam int SPU_TYP_US = 500;
  localparam int HPU_CYC = HPU_TYP_US * CLK_MHZ;
  localparam int SPU_CYC = SPU_TYP_US * CLK_MHZ;
  localparam int PU_MAX_CYC = PU_MAX_US * CLK_MHZ;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ACQ  = 8'h02,
    ST_CVT  = 8'h04,
    ST_SYNC = 8'h08,
    ST_CAL  = 8'h10,
    ST_ZERO = 8'h20,
    ST_DOWN = 8'h40,
    ST_WAKE = 8'h80
  } adcs_state_t;

endpackage

// [design/adcs_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Two-stage synchroniser
// ****************************************
module adcs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// [design/adcs_sequencer.sv]
// Behaviour
// - 12-bit conversion ends within 44 conversion clocks
// - 8-bit conversion ends within 21 conversion clocks
// - Sampling lasts programmed count, plus one
// - Calibration or auto-zero starts 2-3 clocks after strobe
// - Ready strobe high at most 9 serial clocks
// - End-of-conversion rises 250 us after pin release
// - End-of-conversion rises 500 us after power-up command
// - Power-down pin aborts and corrupts running conversion
`timescale 1ns/100ps
`default_nettype none
module adcs_sequencer
  import adcs_pkg::*;
#(
  parameter int HW_WAKE_CYC = adcs_pkg::HPU_CYC,
  parameter int SW_WAKE_CYC = adcs_pkg::SPU_CYC,
  parameter int CAL_LEN = adcs_pkg::CAL_LEN_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pins from the outside world
  input wire logic conversion_clock,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic conversion_select,
  input wire logic power_down_pin,
  // Decoded commands from the serial decoder, one-cycle pulses
  input wire logic cmdStart,
  input wire logic cmdCal,
  input wire logic cmdAutoZero,
  input wire logic cmdPowerUp,
  input wire logic cmdPowerDown,
  input wire logic cmdReadDone,
  // Settings held by the serial decoder
  input wire logic res8,
  input wire logic [1:0] acqSel,
  // Status out
  output logic data_output_ready_n,
  output logic endFlag,
  output logic sampling,
  output logic converting,
  output logic dataValid,
  output logic selLatched
);
  import adcs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    adcs_state_t state;
    logic [12:0] cnt;
    logic [14:0] wake;
    logic calKind;
    logic rdyN;
    logic [3:0] rdyCnt;
    logic [3:0] sckCnt;
    logic selLow;
    logic eoc;
    logic valid;
    logic prevCvClk;
    logic prevSck;
    logic prevOff;
  } adcs_regs_t;

  adcs_regs_t r;
  adcs_regs_t next_r;
  logic [4:0] pinS;
  logic cvClkS, sckS, csS, selS, offS;
  logic cvClkRise, sckRise, sckFall, offRise;
  logic [12:0] acqLen;
  logic [12:0] cvtLen;

  // Pins pass two flops before anything looks at them
  adcs_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({conversion_clock, serial_clk, chip_select_n, conversion_select,
        power_down_pin}),
    .q(pinS)
  );

  assign {cvClkS, sckS, csS, selS, offS} = pinS;
  assign cvClkRise = cvClkS & ~r.prevCvClk;
  assign sckRise = sckS & ~r.prevSck;
  assign sckFall = ~sckS & r.prevSck;
  assign offRise = offS & ~r.prevOff;

  // Programmed sampling window length
  always_comb begin
    case (acqSel)
      2'h0: acqLen = ACQ0_LEN;
      2'h1: acqLen = ACQ1_LEN;
      2'h2: acqLen = ACQ2_LEN;
      default: acqLen = ACQ3_LEN;
    endcase
  end

  // Conversion length by resolution
  assign cvtLen = res8 ? NARROW_LEN : WIDE_LEN;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.prevCvClk = cvClkS;
    next_r.prevSck = sckS;
    next_r.prevOff = offS;
    // Conversion select is taken at the close of its valid window
    if (csS) begin
      next_r.sckCnt = 4'h0;
    end else if (sckRise && r.sckCnt != SEL_VALID_SCLK) begin
      next_r.sckCnt = r.sckCnt + 4'h1;
      if (r.sckCnt == SEL_VALID_SCLK - 4'h1) begin
        next_r.selLow = ~selS;
      end
    end
    // Ready strobe: raised by a read, dropped after 9 serial clocks
    if (cmdReadDone) begin
      next_r.rdyN = 1'b1;
      next_r.rdyCnt = 4'h0;
    end else if (r.rdyN && !csS && sckFall && r.state == ST_IDLE) begin
      next_r.rdyCnt = r.rdyCnt + 4'h1;
      if (r.rdyCnt == RDY_HIGH_SCLK - 4'h1) begin
        next_r.rdyN = 1'b0;
      end
    end else if (!r.rdyN) begin
      // Clear while low, so any later rise starts a fresh count
      next_r.rdyCnt = 4'h0;
    end
    case (r.state)
      ST_IDLE: begin
        next_r.cnt = 13'h0000;
        if (cmdPowerDown) begin
          next_r.state = ST_DOWN;
          next_r.eoc = 1'b0;
        end else if (cmdCal || cmdAutoZero) begin
          // The strobe rises here; the start waits for the domain crossing
          next_r.state = ST_SYNC;
          next_r.calKind = cmdCal;
          next_r.rdyN = 1'b1;
          next_r.eoc = 1'b0;
        end else if (cmdStart && r.selLow) begin
          next_r.state = ST_ACQ;
          next_r.eoc = 1'b0;
          next_r.rdyN = 1'b1;
        end
      end
      ST_ACQ: begin
        // First edge lands within a period, so one more edge is counted
        if (cvClkRise) begin
          next_r.cnt = r.cnt + 13'h0001;
          if (r.cnt == acqLen) begin
            next_r.state = ST_CVT;
            next_r.cnt = 13'h0000;
          end
        end
      end
      ST_CVT: begin
        if (cvClkRise) begin
          next_r.cnt = r.cnt + 13'h0001;
          if (r.cnt == cvtLen - 13'h0001) begin
            next_r.state = ST_IDLE;
            next_r.eoc = 1'b1;
            next_r.rdyN = 1'b0;
            next_r.valid = 1'b1;
          end
        end
      end
      ST_SYNC: begin
        // Third edge falls between two and three periods after the strobe
        if (cvClkRise) begin
          next_r.cnt = r.cnt + 13'h0001;
          if (r.cnt == SYNC_MAX_LEN - 13'h0001) begin
            next_r.state = r.calKind ? ST_CAL : ST_ZERO;
            next_r.cnt = 13'h0000;
          end
        end
      end
      ST_CAL: begin
        if (cvClkRise) begin
          next_r.cnt = r.cnt + 13'h0001;
          if (r.cnt == 13'(CAL_LEN - 1)) begin
            next_r.state = ST_IDLE;
            next_r.eoc = 1'b1;
          end
        end
      end
      ST_ZERO: begin
        if (cvClkRise) begin
          next_r.cnt = r.cnt + 13'h0001;
          if (r.cnt == ZERO_LEN - 13'h0001) begin
            next_r.state = ST_IDLE;
            next_r.eoc = 1'b1;
          end
        end
      end
      ST_DOWN: begin
        // Software wake needs the pin released as well
        if (cmdPowerUp && !offS) begin
          next_r.state = ST_WAKE;
          next_r.wake = 15'(SW_WAKE_CYC - 1);
        end else if (!offS && r.prevOff) begin
          next_r.state = ST_WAKE;
          next_r.wake = 15'(HW_WAKE_CYC - 1);
        end
      end
      ST_WAKE: begin
        if (r.wake == 15'h0000) begin
          next_r.state = ST_IDLE;
          next_r.eoc = 1'b1;
        end else begin
          next_r.wake = r.wake - 15'h0001;
        end
      end
      default: begin
        next_r.state = ST_IDLE;
      end
    endcase
    // The pin wins over everything; a running conversion is lost
    if (offS && r.state != ST_DOWN) begin
      next_r.state = ST_DOWN;
      next_r.eoc = 1'b0;
      if (r.state == ST_ACQ || r.state == ST_CVT) begin
        next_r.valid = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '{state: ST_IDLE, cnt: 13'h0000, wake: 15'h0000, calKind: 1'b0,
             rdyN: 1'b1, rdyCnt: 4'h0, sckCnt: 4'h0, selLow: 1'b0,
             eoc: 1'b1, valid: 1'b0, prevCvClk: 1'b0, prevSck: 1'b0,
             prevOff: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state flops
  // One-hot codes, so a single state bit is itself a flop output
  assign data_output_ready_n = r.rdyN;
  assign endFlag = r.eoc;
  assign sampling = r.state[1];
  assign converting = r.state[2];
  assign dataValid = r.valid;
  assign selLatched = r.selLow;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_conversion_select_end_wide: assert property (
    r.state == ST_CVT && !res8 && cvClkRise && r.cnt == 13'h002B && !offS
    |=> r.state == ST_IDLE && r.eoc && !r.rdyN)
    else $error("wide conversion did not end at 44");
  a_conversion_select_end_narrow: assert property (
    r.state == ST_CVT && res8 && cvClkRise && r.cnt == 13'h0014 && !offS
    |=> r.state == ST_IDLE && r.valid)
    else $error("narrow conversion did not end at 21");
  a_conversion_select_bound: assert property (
    r.state == ST_CVT |-> r.cnt < (res8 ? 13'h0015 : 13'h002C))
    else $error("conversion overran its length");
  a_acq_window: assert property (
    r.state == ST_ACQ && cvClkRise && r.cnt == acqLen && !offS
    |=> r.state == ST_CVT && r.cnt == 13'h0000)
    else $error("sampling window wrong length");
  a_sync_start: assert property (
    r.state == ST_SYNC |-> r.cnt <= 13'h0002)
    else $error("sync start late");
  a_sync_begin: assert property (
    $rose(r.state == ST_CAL || r.state == ST_ZERO)
    |-> $past(r.state) == ST_SYNC && $past(r.cnt) == 13'h0002)
    else $error("sequence began off the third edge");
  a_rdy_high: assert property (
    r.rdyN && !csS && r.state == ST_IDLE |-> r.rdyCnt < 4'h9)
    else $error("ready strobe high too long");
  a_zero_bound: assert property (
    r.state == ST_ZERO |-> r.cnt < 13'h004C && !r.eoc)
    else $error("auto-zero overran");
  a_off_abort: assert property (
    offRise && r.state == ST_CVT
    |=> r.state == ST_DOWN && !r.valid && !r.eoc)
    else $error("power-down did not abort");
  a_wake_eoc: assert property (
    r.state == ST_WAKE && r.wake == 15'h0000 && !offS
    |=> r.eoc && r.state == ST_IDLE)
    else $error("wake did not raise end flag");
  a_wake_bound: assert property (
    r.state == ST_WAKE |-> r.wake < 15'(PU_MAX_CYC))
    else $error("wake exceeds limit");

endmodule
`default_nettype wire

// [design/adcs_sequencer_pad.sv]
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [bench/adcs_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host serial port model
// ****************************************
module adcs_host_model (
  // Serial pins toward the converter
  output logic serial_clk,
  output logic chip_select_n,
  output logic conversion_select
);
  // Idle: clock parked low, device not selected
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    conversion_select = 1'b1;
  end
  // One frame; the serial clock stands still between frames
  task automatic frame(input logic sel, input int nClk);
    chip_select_n = 1'b0;
    conversion_select = sel;
    repeat (nClk) begin
      #160 serial_clk = 1'b1;
      #160 serial_clk = 1'b0;
    end
    // Hold window over, so show the opposite level
    conversion_select = ~sel;
    #160 chip_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// [bench/adcs_sequencer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module adcs_sequencer_tb;
  import adcs_pkg::*;
  localparam int HW_W = 20;
  localparam int SW_W = 30;
  localparam int CAL_L = 40;
  logic clkSys, rst, cvClk, sclk, csN, selPin, offPin, res8;
  logic rdyN, eoc, samp, cvt, dValid, cSel;
  logic [1:0] acqSel;
  logic [5:0] cmd;
  logic [4:0] mon;
  int err_total, comparisons, n;
  // Monitored levels: eoc, ready, sampling, converting, valid
  assign mon = {eoc, rdyN, samp, cvt, dValid};
  adcs_sequencer #(.HW_WAKE_CYC(HW_W), .SW_WAKE_CYC(SW_W),
    .CAL_LEN(CAL_L)) u_dut (
    .clk_sys(clkSys), .rst(rst), .conversion_clock(cvClk),
    .serial_clk(sclk), .chip_select_n(csN),
    .conversion_select(selPin), .power_down_pin(offPin),
    .cmdStart(cmd[0]), .cmdCal(cmd[1]), .cmdAutoZero(cmd[2]),
    .cmdPowerUp(cmd[3]), .cmdPowerDown(cmd[4]), .cmdReadDone(cmd[5]),
    .res8(res8), .acqSel(acqSel), .data_output_ready_n(rdyN),
    .endFlag(eoc), .sampling(samp), .converting(cvt),
    .dataValid(dValid), .selLatched(cSel));
  adcs_host_model u_host (.serial_clk(sclk), .chip_select_n(csN),
    .conversion_select(selPin));
  // ****************************************
  // Clocks and helpers
  // ****************************************
  initial begin
    clkSys = 1'b0;
    forever #20 clkSys = ~clkSys;
  end
  // Free-running, phase unrelated to the system clock
  initial begin
    cvClk = 1'b0;
    #37;
    forever #100 cvClk = ~cvClk;
  end
  task automatic chk(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic range(input string nm, input int lo, hi, g);
    comparisons++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // Counts falling edges until the level shows; bounded
  task automatic waitFor(input int k, input logic v, input int lim);
    n = 0;
    while (mon[k] !== v && n < lim) begin
      @(negedge clkSys);
      n++;
    end
    range("wait", 0, lim - 1, n);
  endtask
  task automatic pulse(input int k);
    @(negedge clkSys);
    cmd[k] = 1'b1;
    @(negedge clkSys);
    cmd = 6'h00;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic conversion_select_run(input logic r8, input logic [1:0] a,
    input int acq, len);
    res8 = r8;
    acqSel = a;
    pulse(0);
    waitFor(2, 1'b1, 20);
    waitFor(2, 1'b0, 2000);
    range("sampling", acq, acq + 1, (n * 40 + 100) / 200);
    waitFor(1, 1'b1, 5);
    waitFor(1, 1'b0, 3000);
    range("convert", len - 1, len, (n * 40 + 100) / 200);
    waitFor(4, 1'b1, 5);
    chk("ready", 1'b0, rdyN);
    chk("valid", 1'b1, dValid);
  endtask
  // Calibration or auto-zero; sync adds up to 3 periods plus edge slack
  task automatic seq_run(input int k, len);
    pulse(k);
    waitFor(4, 1'b0, 5);
    waitFor(4, 1'b1, len * 6 + 100);
    range("seq", len, len + 4, (n * 40 + 100) / 200);
  endtask
  // Pin raised as soon as a conversion starts, so the abort is seen
  task automatic pin_run();
    acqSel = 2'h3;
    pulse(0);
    waitFor(2, 1'b1, 20);
    waitFor(1, 1'b1, 200);
    offPin = 1'b1;
    repeat (3) @(negedge clkSys);
    chk("eoc", 1'b0, eoc);
    chk("valid", 1'b0, dValid);
    offPin = 1'b0;
    waitFor(4, 1'b1, HW_W + 40);
    range("hwWake", HW_W, HW_W + 6, n);
  endtask
  task automatic soft_run();
    pulse(4);
    repeat (2) @(negedge clkSys);
    chk("eoc", 1'b0, eoc);
    pulse(3);
    waitFor(4, 1'b1, SW_W + 40);
    range("swWake", SW_W, SW_W + 6, n);
  endtask
  task automatic ready_run();
    pulse(5);
    chk("ready", 1'b1, rdyN);
    u_host.frame(1'b1, 10);
    chk("ready", 1'b0, rdyN);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is near 100 us; 2 ms means a hang
  initial begin
    #2000000;
    err_total++;
    $display("ERROR watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    rst = 1'b1;
    offPin = 1'b0;
    res8 = 1'b0;
    acqSel = 2'h0;
    cmd = 6'h00;
    err_total = 0;
    comparisons = 0;
    repeat (4) @(negedge clkSys);
    rst = 1'b0;
    repeat (3) @(negedge clkSys);
    chk("eoc", 1'b1, eoc);
    chk("valid", 1'b0, dValid);
    u_host.frame(1'b0, 10);
    repeat (4) @(negedge clkSys);
    chk("selLatched", 1'b1, cSel);
    conversion_select_run(1'b0, 2'h0, 6, 44);
    conversion_select_run(1'b1, 2'h1, 10, 21);
    conversion_select_run(1'b0, 2'h2, 18, 44);
    conversion_select_run(1'b1, 2'h3, 34, 21);
    seq_run(1, CAL_L);
    seq_run(2, 76);
    pin_run();
    soft_run();
    ready_run();
    finish_test();
  end
endmodule
`default_nettype wire
